// ===== dclfm_pkg.sv
// What this block does
// - Each counter is steered by load, latch, clear and enable controls.
// - External mode: two controls from pins, other two from host bits.
// - Counter one uses inputs three and four, counter two seven and eight.
// - Clear high forces count to zero and holds it there.
// - Load high, with clear low, forces and holds the preset; counting resumes from it.
// - Outside frequency mode, count events advance the counter only while enable is high.
// - Rising latch edge copies the count to the snapshot, count undisturbed.
// - Snapshot holds until the next rising latch edge.
// - Inputs one to four serve counter A, five to eight counter B.
// - Host writes 32-bit preset per counter; load transfers it in.
// - Each counter's latched snapshot is readable by the host.
// - Live count, or latest frequency, readable per channel as one 32-bit word.
// - Mode and configuration writes take effect only while override mask set.
// - Frequency mode measures clock A, clock B, or both alternately.
// - Frequency gate state readable as a status bit.
// - Frequency measurements repeat automatically, updating latest results.
// - Time base of 10,000,000 ticks gives one second gate, result in hertz.
// - Count wraps at zero downward and at full range upward.
// - Timer mode counts internal 10 MHz ticks instead of the clock pin.
package dclfm_pkg;

  // Clocking and internal time base
  localparam int unsigned CLK_HZ   = 125_000_000;
  localparam int unsigned TICK_HZ  = 10_000_000;
  localparam int unsigned TICK_GCD = 5_000_000;
  localparam logic [5:0]  TICK_STEP = 6'(TICK_HZ / TICK_GCD);
  localparam logic [5:0]  TICK_MOD  = 6'(CLK_HZ / TICK_GCD);

  // Register byte addresses
  localparam logic [7:0] A_OPTION   = 8'h00;
  localparam logic [7:0] A_LIVE_A   = 8'h04;
  localparam logic [7:0] A_LIVE_B   = 8'h08;
  localparam logic [7:0] A_SNAP_A   = 8'h0C;
  localparam logic [7:0] A_SNAP_B   = 8'h10;
  localparam logic [7:0] A_PRESET_A = 8'h14;
  localparam logic [7:0] A_PRESET_B = 8'h18;
  localparam logic [7:0] A_PULSE_AC = 8'h1C;
  localparam logic [7:0] A_PULSE_AO = 8'h20;
  localparam logic [7:0] A_PULSE_BC = 8'h24;
  localparam logic [7:0] A_PULSE_BO = 8'h28;
  localparam logic [7:0] A_CONTROL  = 8'h2C;
  localparam logic [7:0] A_CFG_A    = 8'h30;
  localparam logic [7:0] A_CFG_B    = 8'h34;
  localparam logic [7:0] A_FREQ_CFG = 8'h38;
  localparam logic [7:0] A_STATUS   = 8'h3C;

  // Field positions and values
  localparam int unsigned CTL_ONE_LSB = 0;
  localparam int unsigned CTL_TWO_LSB = 4;
  localparam int unsigned CTL_MASK    = 8;
  localparam logic [15:0] OPTION_NUMBER = 16'h0001;
  localparam logic [1:0]  FN_LATCH  = 2'h0;
  localparam logic [1:0]  FN_LOAD   = 2'h1;
  localparam logic [1:0]  FN_CLEAR  = 2'h2;
  localparam logic [1:0]  FN_ENABLE = 2'h3;
  localparam logic [1:0]  SEL_A     = 2'h0;
  localparam logic [1:0]  SEL_B     = 2'h1;
  localparam logic [1:0]  SEL_ALT   = 2'h2;
  localparam logic [5:0]  CFG_RST   = 6'h00;
  localparam logic [2:0]  FCFG_RST  = 3'h0;

  // Control group: bit 0 latch, 1 load, 2 clear, 3 enable
  typedef struct packed {
    logic enable;
    logic clear;
    logic load;
    logic latch;
  } dclfm_ctrl_t;

  // Per-counter configuration
  typedef struct packed {
    logic       timer;
    logic [1:0] fn_hi;
    logic [1:0] fn_lo;
    logic       ext;
  } dclfm_cfg_t;

  // Frequency mode configuration
  typedef struct packed {
    logic [1:0] sel;
    logic       en;
  } dclfm_fcfg_t;

  typedef enum logic [1:0] {FM_IDLE, FM_GATE, FM_STORE} dclfm_fm_t;

  // Whole block state
  typedef struct packed {
    logic [7:0]       sync1;
    logic [7:0]       sync2;
    logic [7:0]       sync3;
    logic [7:0]       filt;
    logic [7:0]       filt_d;
    logic [5:0]       acc;
    dclfm_ctrl_t      ctl1;
    dclfm_ctrl_t      ctl2;
    logic             mask;
    dclfm_cfg_t [1:0] cfg;
    dclfm_fcfg_t      fcfg;
    logic [1:0][31:0] preset;
    logic [1:0][31:0] cnt;
    logic [1:0][31:0] snap;
    logic [1:0][31:0] freq;
    logic [1:0]       latch_d;
    dclfm_fm_t        fm;
    logic             fm_ch;
    logic [31:0]      rdata;
  } dclfm_state_t;

endpackage : dclfm_pkg

// ===== dclfm_top.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module dclfm_top
  import dclfm_pkg::*;
(
  input  wire logic        REF_CLK_I,  // 125 MHz clock
  input  wire logic        RST_N_I,    // Async reset, active low
  input  wire logic [7:0]  IN_I,       // External inputs 1..8 on bits 0..7
  input  wire logic [7:0]  ADDR_I,     // Register byte address
  input  wire logic [31:0] WDATA_I,    // Write data
  input  wire logic        WR_I,       // Write strobe
  input  wire logic        RD_I,       // Read strobe
  output logic      [31:0] RDATA_O     // Read data, cycle after RD_I
);

  dclfm_state_t st_reg;
  dclfm_state_t st_next;

  // Merge host bits with the two pin-driven functions
  function automatic dclfm_ctrl_t dclfm_eff_ctrl(input dclfm_ctrl_t host,
                                                 input dclfm_cfg_t  cfg,
                                                 input logic [1:0]  pins);
    dclfm_ctrl_t c;
    logic [1:0]  fn;
    c = host;
    if (cfg.ext) begin
      for (int k = 0; k < 2; k++) begin
        fn = (k == 0) ? cfg.fn_lo : cfg.fn_hi;
        case (fn)
          FN_LATCH: c.latch  = pins[k];
          FN_LOAD:  c.load   = pins[k];
          FN_CLEAR: c.clear  = pins[k];
          default:  c.enable = pins[k];
        endcase
      end
    end
    return c;
  endfunction : dclfm_eff_ctrl

  // Next-state logic for the whole block
  always_comb begin
    dclfm_ctrl_t c [2];
    logic        tick;
    logic [5:0]  sum;
    logic        ev;
    logic        up;
    logic        lat_rise;
    logic [31:0] tb;
    logic        edge_sel;
    st_next = st_reg;
    c[0] = '0;
    c[1] = '0;
    sum = 6'h00;
    tick = 1'b0;
    ev = 1'b0;
    up = 1'b0;
    lat_rise = 1'b0;
    tb = 32'h0000_0000;
    edge_sel = 1'b0;

    // Three-stage sync; a level counts once stages two and three agree
    st_next.sync1  = IN_I;
    st_next.sync2  = st_reg.sync1;
    st_next.sync3  = st_reg.sync2;
    st_next.filt   = (~(st_reg.sync2 ^ st_reg.sync3) & st_reg.sync3)
                   | ((st_reg.sync2 ^ st_reg.sync3) & st_reg.filt);
    st_next.filt_d = st_reg.filt;

    // 10 MHz tick from 125 MHz by fractional accumulation, jitter of one cycle
    sum = st_reg.acc + TICK_STEP;
    if (sum >= TICK_MOD) begin
      st_next.acc = sum - TICK_MOD;
      tick = 1'b1;
    end else begin
      st_next.acc = sum;
    end

    // Effective controls per counter, pins 3,4 for A and 7,8 for B
    c[0] = dclfm_eff_ctrl(st_reg.ctl1, st_reg.cfg[0], st_reg.filt[3:2]);
    c[1] = dclfm_eff_ctrl(st_reg.ctl2, st_reg.cfg[1], st_reg.filt[7:6]);

    if (!st_reg.fcfg.en) begin
      st_next.fm    = FM_IDLE;
      st_next.fm_ch = (st_reg.fcfg.sel == SEL_B);
      for (int i = 0; i < 2; i++) begin
        // Clock on the first pin of the group, direction on the second
        ev = st_reg.cfg[i].timer ? tick
                                 : (st_reg.filt[4*i] & ~st_reg.filt_d[4*i]);
        up = st_reg.filt[4*i+1];
        if (c[i].clear) begin
          st_next.cnt[i] = 32'h0000_0000;
        end else if (c[i].load) begin
          st_next.cnt[i] = st_reg.preset[i];
        end else if (c[i].enable && ev) begin
          // Plain 32-bit add and subtract wrap at both ends
          st_next.cnt[i] = up ? st_reg.cnt[i] + 32'h0000_0001
                              : st_reg.cnt[i] - 32'h0000_0001;
        end
        lat_rise = c[i].latch & ~st_reg.latch_d[i];
        if (lat_rise) begin
          st_next.snap[i] = st_reg.cnt[i];
        end
        st_next.latch_d[i] = c[i].latch;
      end
    end else begin
      // Counter A times the gate, counter B counts input edges
      tb = (st_reg.preset[st_reg.fm_ch] == 32'h0000_0000)
         ? 32'h0000_0001 : st_reg.preset[st_reg.fm_ch];
      edge_sel = st_reg.fm_ch ? (st_reg.filt[4] & ~st_reg.filt_d[4])
                              : (st_reg.filt[0] & ~st_reg.filt_d[0]);
      case (st_reg.fm)
        FM_IDLE: begin
          st_next.cnt = '0;
          st_next.fm  = FM_GATE;
        end
        FM_GATE: begin
          if (tick) begin
            st_next.cnt[0] = st_reg.cnt[0] + 32'h0000_0001;
          end
          if (edge_sel) begin
            st_next.cnt[1] = st_reg.cnt[1] + 32'h0000_0001;
          end
          // One tick is 100 ns, so a one-second base reads out hertz
          if (tick && (st_reg.cnt[0] >= tb - 32'h0000_0001)) begin
            st_next.fm = FM_STORE;
          end
        end
        FM_STORE: begin
          st_next.freq[st_reg.fm_ch] = st_reg.cnt[1];
          st_next.fm_ch = (st_reg.fcfg.sel == SEL_ALT) ? ~st_reg.fm_ch
                                                       : (st_reg.fcfg.sel == SEL_B);
          st_next.fm = FM_IDLE;
        end
        default: st_next.fm = FM_IDLE;
      endcase
    end

    // Register writes
    if (WR_I) begin
      case (ADDR_I)
        A_PRESET_A: st_next.preset[0] = WDATA_I;
        A_PRESET_B: st_next.preset[1] = WDATA_I;
        A_CONTROL: begin
          st_next.ctl1 = WDATA_I[CTL_ONE_LSB +: 4];
          st_next.ctl2 = WDATA_I[CTL_TWO_LSB +: 4];
          st_next.mask = WDATA_I[CTL_MASK];
        end
        // Setup stays frozen unless the override mask is set
        A_CFG_A: begin
          if (st_reg.mask) begin
            st_next.cfg[0] = WDATA_I[5:0];
          end
        end
        A_CFG_B: begin
          if (st_reg.mask) begin
            st_next.cfg[1] = WDATA_I[5:0];
          end
        end
        A_FREQ_CFG: begin
          if (st_reg.mask) begin
            st_next.fcfg = WDATA_I[2:0];
          end
        end
        default: ;  // Pulse times and read-only words are ignored
      endcase
    end

    // Read data stands only in the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (RD_I) begin
      case (ADDR_I)
        A_OPTION:   st_next.rdata = {16'h0000, OPTION_NUMBER};
        A_LIVE_A:   st_next.rdata = st_reg.fcfg.en ? st_reg.freq[0] : st_reg.cnt[0];
        A_LIVE_B:   st_next.rdata = st_reg.fcfg.en ? st_reg.freq[1] : st_reg.cnt[1];
        A_SNAP_A:   st_next.rdata = st_reg.snap[0];
        A_SNAP_B:   st_next.rdata = st_reg.snap[1];
        A_CFG_A:    st_next.rdata = {26'h000_0000, st_reg.cfg[0]};
        A_CFG_B:    st_next.rdata = {26'h000_0000, st_reg.cfg[1]};
        A_FREQ_CFG: st_next.rdata = {29'h0000_0000, st_reg.fcfg};
        A_STATUS:   st_next.rdata = {30'h0000_0000, st_reg.fm_ch,
                                     (st_reg.fm == FM_GATE)};
        default:    st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg        <= '0;
      st_reg.cfg[0] <= CFG_RST;
      st_reg.cfg[1] <= CFG_RST;
      st_reg.fcfg   <= FCFG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA_O = st_reg.rdata;

endmodule : dclfm_top
`default_nettype wire

// ===== dclfm_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module dclfm_chk
  import dclfm_pkg::*;
(
  input wire logic        REF_CLK_I, // Clock
  input wire logic        RST_N_I,   // Reset, active low
  input wire logic [7:0]  IN_I,      // Pins
  input wire logic [7:0]  ADDR_I,    // Address
  input wire logic [31:0] WDATA_I,   // Write data
  input wire logic        WR_I,      // Write strobe
  input wire logic        RD_I,      // Read strobe
  input wire logic [31:0] RDATA_O    // Read data
);
  logic [8:0]  ctl_q;
  logic        ext_q;
  logic        fen_q;
  logic [31:0] pre_q;
  logic [1:0]  quiet;
  logic        ok_a;
  logic        rd_a;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Shadow of host settings; config follows the mask as the block does
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctl_q <= 9'h000;
      ext_q <= 1'b0;
      fen_q <= 1'b0;
      pre_q <= 32'h0;
      quiet <= 2'h0;
    end else begin
      if (WR_I && ADDR_I == A_CONTROL) ctl_q <= WDATA_I[8:0];
      if (WR_I && ADDR_I == A_CFG_A && ctl_q[8]) ext_q <= WDATA_I[0];
      if (WR_I && ADDR_I == A_FREQ_CFG && ctl_q[8]) fen_q <= WDATA_I[0];
      if (WR_I && ADDR_I == A_PRESET_A) pre_q <= WDATA_I;
      quiet <= WR_I ? 2'h0 : quiet + 2'(quiet != 2'h3);
    end
  end
  // Only judge channel A once host bits have settled and pins cannot steer it
  assign ok_a = !ext_q && !fen_q && quiet == 2'h3;
  assign rd_a = RD_I && ADDR_I == A_LIVE_A && ok_a;
  chk_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data not zero outside a read");
  chk_preset_wo: assert property (RD_I && (ADDR_I == A_PRESET_A || ADDR_I == A_PRESET_B)
    |=> RDATA_O == 32'h0) else $error("preset read not zero");
  chk_mask_wo: assert property (RD_I && ADDR_I == A_CONTROL |=> RDATA_O == 32'h0)
    else $error("control read not zero");
  chk_cfg_gated: assert property (RD_I && ADDR_I == A_CFG_A |=> RDATA_O[0] == $past(ext_q))
    else $error("config bit changed without mask");
  chk_status_bits: assert property (RD_I && ADDR_I == A_STATUS |=> RDATA_O[31:2] == 30'h0)
    else $error("status upper bits set");
  chk_clear_zero: assert property (rd_a && ctl_q[2] |=> RDATA_O == 32'h0)
    else $error("count not zero under clear");
  chk_load_value: assert property (rd_a && ctl_q[2:1] == 2'h1 |=> RDATA_O == $past(pre_q))
    else $error("count not at preset under load");
  chk_hold_count: assert property (rd_a && ctl_q[3:1] == 3'h0 ##2 rd_a
    |=> RDATA_O == $past(RDATA_O, 2)) else $error("count moved while disabled");
  cover property (rd_a && ctl_q[2]);
  cover property (rd_a && ctl_q[2:1] == 2'h1);
  cover property (RD_I && ADDR_I == A_CFG_A && ext_q);
endmodule : dclfm_chk
bind dclfm_top dclfm_chk dclfm_chk_inst (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .IN_I(IN_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O));
`default_nettype wire

// ===== dclfm_pulse_src.sv
`timescale 1ns/100ps
`default_nettype none
module dclfm_pulse_src (
  input  wire logic       clk_i,   // Bench clock
  input  wire logic       go_i,    // Start a burst
  input  wire logic [7:0] n_i,     // Rising edges wanted
  output logic            pulse_o, // Clock pin level
  output logic            busy_o   // Burst running
);
  logic [7:0] left = 8'h00;
  logic [2:0] ph   = 3'h0;
  // Four low, four high: slow enough that the pin filter never drops one
  always_ff @(posedge clk_i) begin
    ph <= go_i ? 3'h0 : ph + 3'h1;
    if (go_i) left <= n_i;
    else if (busy_o && ph == 3'h7) left <= left - 8'h01;
  end
  // Pin rests low between bursts
  assign busy_o  = left != 8'h00;
  assign pulse_o = busy_o && ph[2];
endmodule : dclfm_pulse_src
`default_nettype wire

// ===== dclfm_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dclfm_tb_top;
  import dclfm_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        mask  = 1'b0;
  logic [1:0]  go    = 2'h0;
  logic [1:0]  dir   = 2'h3;
  logic [3:0]  pins  = 4'h0;
  logic [7:0]  n     = 8'h00;
  logic [31:0] rdata;
  logic [1:0]  pul;
  logic [1:0]  busy;
  int          mismatches = 0;
  int          check_count = 0;
  always #4 clk = ~clk;
  dclfm_top dclfm_top_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .IN_I({pins[3:2], dir[1], pul[1], pins[1:0], dir[0], pul[0]}),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
  for (genvar g = 0; g < 2; g++) begin : g_src
    dclfm_pulse_src dclfm_pulse_src_inst (.clk_i(clk), .go_i(go[g]), .n_i(n),
      .pulse_o(pul[g]), .busy_o(busy[g]));
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(nm, d, exp);
  endtask : rd_chk
  // Control word for one counter; the other group stays idle
  task automatic ctl(input int ch, input logic [3:0] c);
    wr_reg(A_CONTROL, {23'h0, mask, 8'(c) << (4 * ch)});
    repeat (3) @(posedge clk);
  endtask : ctl
  task automatic burst(input int ch, input logic [7:0] k, input bit w);
    @(posedge clk);
    n <= k;
    go[ch] <= 1'b1;
    @(posedge clk);
    go[ch] <= 1'b0;
    #1;
    for (int i = 0; i < 2100 && w && busy[ch] === 1'b1; i++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : burst
  task automatic t_count(input int ch);
    logic [7:0] o;
    o = 8'(4 * ch);
    wr_reg(A_PRESET_A + o, 32'h1);
    ctl(ch, 4'h2);
    rd_chk("load", A_LIVE_A + o, 32'h1);
    dir[ch] <= 1'b0;
    ctl(ch, 4'h8);
    burst(ch, 8'h02, 1'b1);
    rd_chk("wrap down", A_LIVE_A + o, 32'hFFFFFFFF);
    dir[ch] <= 1'b1;
    burst(ch, 8'h03, 1'b1);
    rd_chk("wrap up", A_LIVE_A + o, 32'h2);
    ctl(ch, 4'h9);
    rd_chk("snap", A_SNAP_A + o, 32'h2);
    ctl(ch, 4'h8);
    burst(ch, 8'h03, 1'b1);
    rd_chk("live", A_LIVE_A + o, 32'h5);
    rd_chk("snap held", A_SNAP_A + o, 32'h2);
    ctl(ch, 4'h0);
    burst(ch, 8'h02, 1'b1);
    rd_chk("disabled", A_LIVE_A + o, 32'h5);
    rd_chk("disabled", A_LIVE_A + o, 32'h5);
    ctl(ch, 4'hE);
    rd_chk("clear wins", A_LIVE_A + o, 32'h0);
    mask = 1'b1;
    ctl(ch, 4'h8);
    wr_reg(A_CFG_A + o, 32'h11);
    burst(ch, 8'h03, 1'b1);
    rd_chk("host enable", A_LIVE_A + o, 32'h3);
    pins[2 * ch +: 2] <= 2'b01;
    repeat (8) @(posedge clk);
    rd_chk("pin latch", A_SNAP_A + o, 32'h3);
    pins[2 * ch +: 2] <= 2'b11;
    repeat (8) @(posedge clk);
    rd_chk("pin clear", A_LIVE_A + o, 32'h0);
    pins[2 * ch +: 2] <= 2'b00;
    wr_reg(A_CFG_A + o, 32'h0);
    mask = 1'b0;
    // Drop the mask in the block too, or later setup writes still land
    ctl(ch, 4'h0);
  endtask : t_count
  task automatic t_regs;
    rd_chk("option", A_OPTION, 32'h1);
    rd_chk("preset", A_PRESET_B, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr_reg(A_CFG_A, 32'h1);
    rd_chk("cfg masked", A_CFG_A, 32'h0);
  endtask : t_regs
  task automatic t_freq;
    logic [31:0] d;
    logic [1:0]  g;
    logic [1:0]  h;
    mask = 1'b1;
    ctl(0, 4'h8);
    wr_reg(A_CFG_A, 32'h20);
    repeat (250) @(posedge clk);
    rd_reg(A_LIVE_A, d);
    chk("timer", 32'(d >= 32'd18 && d <= 32'd22), 32'h1);
    wr_reg(A_PRESET_A, 32'h5);
    wr_reg(A_PRESET_B, 32'h5);
    burst(0, 8'hFF, 1'b0);
    burst(1, 8'hFF, 1'b0);
    for (int s = 0; s < 3; s++) begin
      wr_reg(A_FREQ_CFG, {29'h0, 2'(s), 1'b1});
      repeat (300) @(posedge clk);
      rd_reg(s == 1 ? A_LIVE_B : A_LIVE_A, d);
      chk("freq", 32'(d >= 32'd6 && d <= 32'd9), 32'h1);
    end
    // Alternate mode still on: both gate levels and both channels must show
    g = 2'h0;
    h = 2'h0;
    for (int i = 0; i < 60; i++) begin
      rd_reg(A_STATUS, d);
      g[d[0]] = 1'b1;
      h[d[1]] = 1'b1;
    end
    chk("gate", 32'(g), 32'h3);
    chk("alternate", 32'(h), 32'h3);
    wr_reg(A_FREQ_CFG, 32'h0);
  endtask : t_freq
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task automatic test_done;
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // Main sequence, with a second reset in mid-run
  initial begin
    do_reset();
    t_count(0);
    t_count(1);
    t_regs();
    do_reset();
    rd_chk("after reset", A_LIVE_B, 32'h0);
    t_freq();
    test_done();
  end
  // Watchdog well beyond the two thousand or so cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule : dclfm_tb_top
`default_nettype wire
